//--- rtl/sfm_pkg.sv
// Package of constants and types for the servo fault manager
package sfm_pkg;

  // ==========================================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] SFM_OFS_CTRL     = 8'h00;
  localparam logic [7:0] SFM_OFS_ALARM    = 8'h04;
  localparam logic [7:0] SFM_OFS_ACTIVE   = 8'h08;
  localparam logic [7:0] SFM_OFS_HIST_SEL = 8'h0C;
  localparam logic [7:0] SFM_OFS_HIST_CODE= 8'h10;
  localparam logic [7:0] SFM_OFS_SNAP0    = 8'h14;
  localparam logic [7:0] SFM_OFS_PARAM    = 8'h34;
  localparam logic [7:0] SFM_OFS_STATUS   = 8'h38;
  localparam logic [7:0] SFM_OFS_SNAPIN   = 8'h3C;

  // ==========================================================================
  // Control register field positions
  localparam int SFM_CTRL_INIT_LSB = 0;
  localparam int SFM_CTRL_FAST_BIT = 2;
  localparam int SFM_CTRL_MAP_BIT  = 3;

  // ==========================================================================
  // Class nibbles of a stored code
  localparam logic [3:0] SFM_CLS_NR1 = 4'h0;
  localparam logic [3:0] SFM_CLS_R1  = 4'h2;
  localparam logic [3:0] SFM_CLS_R2  = 4'h6;
  localparam logic [3:0] SFM_CLS_W3  = 4'hE;

  // ==========================================================================
  // Sizes, timing, reset values
  localparam int SFM_HIST_DEPTH  = 10;
  localparam int SFM_DEDUP_DEPTH = 5;
  localparam int SFM_SNAP_NUM    = 8;
  localparam int SFM_CLK_HZ      = 25_000_000;
  localparam int SFM_RST_HOLD_US = 3000;
  localparam int SFM_RST_HOLD_CYC = (SFM_CLK_HZ / 1_000_000) * SFM_RST_HOLD_US + 1;
  localparam logic [15:0] SFM_CODE_NONE = 16'h0000;
  localparam logic [31:0] SFM_ZERO32    = 32'h0000_0000;

  // ==========================================================================
  // Clear sequencer states
  typedef enum logic [1:0]
  {
    SFM_ST_IDLE  = 2'b00,
    SFM_ST_WAIT  = 2'b01,
    SFM_ST_CLEAR = 2'b10,
    SFM_ST_DONE  = 2'b11
  } sfm_clr_e;

  // Severity rank of a class nibble, 3 is highest
  function automatic logic [1:0] sfm_rank(input logic [3:0] cls);
    case (cls)
      SFM_CLS_NR1: sfm_rank = 2'd3;
      SFM_CLS_R1:  sfm_rank = 2'd3;
      SFM_CLS_R2:  sfm_rank = 2'd2;
      default:     sfm_rank = 2'd1;
    endcase
  endfunction

endpackage

//--- rtl/sfm_hist_if.sv
// Interface carrying history store requests and readout
`timescale 1ns/1ps
interface sfm_hist_if;
  import sfm_pkg::*;
  logic        push;
  logic [15:0] push_code;
  logic [31:0] push_snap [SFM_SNAP_NUM];
  logic        erase;
  logic [3:0]  sel;
  logic [15:0] rd_code;
  logic [31:0] rd_snap [SFM_SNAP_NUM];
  logic [3:0]  count;

  modport ctl (output push, push_code, push_snap, erase, sel,
               input rd_code, rd_snap, count);
  modport mem (input push, push_code, push_snap, erase, sel,
               output rd_code, rd_snap, count);
endinterface

//--- rtl/sfm_history.sv
// Ten-entry alarm history with deduplication
`timescale 1ns/1ps
module sfm_history
  import sfm_pkg::*;
#(
  parameter int DEPTH = SFM_HIST_DEPTH,
  parameter int DEDUP = SFM_DEDUP_DEPTH
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_sync_n,
  // Store and readout
  sfm_hist_if.mem  h
);

  initial
  begin
    if (DEDUP > DEPTH || DEPTH > 15)
      $error("sfm_history: bad depth");
  end

  // ==========================================================================
  // Storage, entry 0 is most recent
  logic [15:0] code_r [DEPTH];
  logic [15:0] code_nxt [DEPTH];
  logic [31:0] snap_r [DEPTH][SFM_SNAP_NUM];
  logic [31:0] snap_nxt [DEPTH][SFM_SNAP_NUM];
  logic [3:0]  cnt_r;
  logic [3:0]  cnt_nxt;
  logic        dup;

  always_comb
  begin
    dup = 1'b0;
    for (int i = 0; i < DEDUP; i++)
      if (4'(i) < cnt_r && code_r[i] == h.push_code)
        dup = 1'b1;                                           // RULE11
    code_nxt = code_r;
    snap_nxt = snap_r;
    cnt_nxt  = cnt_r;
    if (h.erase)
    begin
      cnt_nxt = 4'h0;                                         // RULE12
      for (int i = 0; i < DEPTH; i++)
        code_nxt[i] = SFM_CODE_NONE;
    end
    else if (h.push && !dup)
    begin
      for (int i = DEPTH - 1; i > 0; i--)
      begin
        code_nxt[i] = code_r[i-1];                            // RULE19
        snap_nxt[i] = snap_r[i-1];
      end
      code_nxt[0] = h.push_code;                              // RULE10
      snap_nxt[0] = h.push_snap;
      if (cnt_r < 4'(DEPTH))
        cnt_nxt = cnt_r + 4'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      cnt_r <= 4'h0;
      for (int i = 0; i < DEPTH; i++)
      begin
        code_r[i] <= SFM_CODE_NONE;
        for (int j = 0; j < SFM_SNAP_NUM; j++)
          snap_r[i][j] <= SFM_ZERO32;
      end
    end
    else
    begin
      cnt_r  <= cnt_nxt;
      code_r <= code_nxt;
      snap_r <= snap_nxt;
    end
  end

  // ==========================================================================
  // Readout of entry sel
  always_comb
  begin
    h.rd_code = SFM_CODE_NONE;                                // RULE14
    for (int j = 0; j < SFM_SNAP_NUM; j++)
      h.rd_snap[j] = SFM_ZERO32;
    if (h.sel < cnt_r)
    begin
      h.rd_code = code_r[h.sel];                              // RULE13
      h.rd_snap = snap_r[h.sel];
    end
  end
  assign h.count = cnt_r;

endmodule

//--- rtl/sfm_top.sv
// Servo fault manager: alarm grading, clearing, history and coded outputs
// Summary of operation
// RULE1 - Four alarm classes, class 1 highest
// RULE2 - Non-resettable class-1 faults never cleared
// RULE3 - Reset only while reset input valid
// RULE4 - Class 1/2 reset needs servo enable off
// RULE5 - Class-3 warning clears on reset alone
// RULE6 - Reset level must hold over 3 ms
// RULE7 - Reset on fast input is ignored
// RULE8 - Active cause blocks reset; settings not applied
// RULE9 - Shutdown settings apply after enable off
// RULE10 - History keeps last ten alarms with snapshot
// RULE11 - Repeat within last five stored once
// RULE12 - History erased only by init 1 or 2
// RULE13 - Index selects entry; code plus eight values
// RULE14 - Empty entry reads code zero
// RULE15 - Code: class nibble plus alarm number
// RULE16 - Reader converts decimal code to hex
// RULE17 - Three outputs carry code bits one-three
// RULE18 - Example patterns per alarm bit table
// RULE19 - History circular, newest is entry one; code shifts entries and keeps the newest at entry 0
// RULE20 - Highest class wins, earliest within class
`timescale 1ns/1ps
module sfm_top
  import sfm_pkg::*;
#(
  parameter int RST_HOLD_CYC = SFM_RST_HOLD_CYC
)
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Drive pins
  input  wire logic        alarm_clear_request,
  input  wire logic        servo_enable,
  input  wire logic        alarm_cause_present,
  // Coded alarm outputs
  output logic             code_out_b1,
  output logic             code_out_b2,
  output logic             code_out_b3,
  // Active alarm and settings status
  output logic             alarm_active,
  output logic             settings_applied
);

  initial
  begin
    if (RST_HOLD_CYC < 1 || RST_HOLD_CYC > 2**24 - 1)
      $error("sfm_top: bad hold count");
  end

  // ==========================================================================
  // Reset release and pin synchronisers
  logic rst_m_r, rst_sync_n;
  logic [2:0] pin_m_r, pin_s_r;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_m_r    <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_m_r    <= 1'b1;
      rst_sync_n <= rst_m_r;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      pin_m_r <= 3'b000;
      pin_s_r <= 3'b000;
    end
    else
    begin
      pin_m_r <= {alarm_cause_present, servo_enable, alarm_clear_request};
      pin_s_r <= pin_m_r;
    end
  end

  logic clr_pin, son, cause;
  assign clr_pin = pin_s_r[0];
  assign son     = pin_s_r[1];
  assign cause   = pin_s_r[2];

  // ==========================================================================
  // Registers
  logic [31:0] ctrl_r, ctrl_nxt;
  logic [31:0] alarm_r, alarm_nxt;
  logic [31:0] sel_r, sel_nxt;
  logic [31:0] param_r, param_nxt;
  logic [31:0] pend_r, pend_nxt;
  logic        pend_v_r, pend_v_nxt;
  logic [31:0] snapin_r [SFM_SNAP_NUM];
  logic [31:0] snapin_nxt [SFM_SNAP_NUM];
  logic        raise;

  // Active alarm and clear sequencer
  logic [15:0] act_code_r, act_code_nxt;
  logic        act_r, act_nxt;
  logic [23:0] hold_r, hold_nxt;
  logic        rst_ok;
  sfm_clr_e    st_r, st_nxt;

  sfm_hist_if hif ();

  logic wr, rd;
  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign raise = wr && paddr == SFM_OFS_ALARM;

  // ==========================================================================
  // Software register updates
  always_comb
  begin
    ctrl_nxt   = ctrl_r;
    alarm_nxt  = alarm_r;
    sel_nxt    = sel_r;
    param_nxt  = param_r;
    pend_nxt   = pend_r;
    pend_v_nxt = pend_v_r;
    snapin_nxt = snapin_r;
    if (wr)
    begin
      case (paddr)
        SFM_OFS_CTRL:     ctrl_nxt = pwdata;
        SFM_OFS_ALARM:    alarm_nxt = pwdata;
        SFM_OFS_HIST_SEL: sel_nxt = {28'h000_0000, pwdata[3:0]};
        SFM_OFS_PARAM:
        begin
          pend_nxt   = pwdata;
          pend_v_nxt = 1'b1;
        end
        default:
        begin
          if (paddr >= SFM_OFS_SNAPIN && paddr < SFM_OFS_SNAPIN + 8'(4 * SFM_SNAP_NUM) &&
              paddr[1:0] == 2'b00)
            snapin_nxt[3'((paddr - SFM_OFS_SNAPIN) >> 2)] = pwdata;
        end
      endcase
    end
    if (wr && paddr == SFM_OFS_CTRL)
      ctrl_nxt[1:0] = 2'b00;
    if (pend_v_r && !son && !(wr && paddr == SFM_OFS_PARAM))
    begin
      param_nxt  = pend_r;                                    // RULE9
      pend_v_nxt = 1'b0;                                      // RULE8
    end
  end

  // ==========================================================================
  // Alarm grading and clearing
  logic valid_cls;
  assign valid_cls = alarm_nxt[15:12] inside {SFM_CLS_NR1, SFM_CLS_R1, SFM_CLS_R2, SFM_CLS_W3};
  // Coded pin pattern of an alarm
  function automatic logic [2:0] sfm_al_bits(input logic [15:0] code);
    case (code[11:0])
      12'h400: sfm_al_bits = 3'b011;                          // RULE18
      12'h500: sfm_al_bits = 3'b010;                          // RULE18
      12'hB00: sfm_al_bits = 3'b100;                          // RULE18
      default: sfm_al_bits = code[3:1];                       // RULE17
    endcase
  endfunction
  logic [2:0] al_nxt;
  assign al_nxt = sfm_al_bits(act_code_nxt);

  always_comb
  begin
    st_nxt       = st_r;
    hold_nxt     = hold_r;
    act_code_nxt = act_code_r;
    act_nxt      = act_r;
    rst_ok       = 1'b0;
    if (!clr_pin || !ctrl_r[SFM_CTRL_MAP_BIT] || ctrl_r[SFM_CTRL_FAST_BIT])
    begin
      st_nxt   = SFM_ST_IDLE;                                 // RULE3 RULE7
      hold_nxt = 24'h00_0000;
    end
    else
    begin
      case (st_r)
        SFM_ST_IDLE:
        begin
          st_nxt   = SFM_ST_WAIT;
          hold_nxt = 24'h00_0001;
        end
        SFM_ST_WAIT:
        begin
          hold_nxt = hold_r + 24'h00_0001;
          if (hold_r >= 24'(RST_HOLD_CYC))
            st_nxt = SFM_ST_CLEAR;                            // RULE6
        end
        SFM_ST_CLEAR:
        begin
          rst_ok = 1'b1;
          st_nxt = SFM_ST_DONE;
        end
        SFM_ST_DONE: st_nxt = SFM_ST_DONE;
        default:     st_nxt = SFM_ST_IDLE;
      endcase
    end
    if (rst_ok && act_r && !cause)                            // RULE8
    begin
      case (act_code_r[15:12])
        SFM_CLS_NR1: act_nxt = 1'b1;                          // RULE2
        SFM_CLS_W3:  act_nxt = 1'b0;                          // RULE5
        default:     act_nxt = son;                           // RULE4
      endcase
    end
    if (raise && valid_cls)
    begin
      if (!act_nxt || sfm_rank(alarm_nxt[15:12]) > sfm_rank(act_code_nxt[15:12])) // RULE1
        act_code_nxt = alarm_nxt[15:0];                       // RULE20
      act_nxt = 1'b1;
    end
  end
  // History connections
  assign hif.push      = raise && valid_cls;                  // RULE10
  assign hif.push_code = pwdata[15:0];                        // RULE15
  assign hif.push_snap = snapin_r;
  assign hif.erase     = wr && paddr == SFM_OFS_CTRL &&
                         (pwdata[1:0] == 2'd1 || pwdata[1:0] == 2'd2); // RULE12
  assign hif.sel       = sel_r[3:0];

  sfm_history u_hist
  (
    .clk_sys    (clk_sys),
    .rst_sync_n (rst_sync_n),
    .h          (hif)
  );

  // ==========================================================================
  // APB read data
  logic [31:0] rdata_nxt;
  always_comb
  begin
    rdata_nxt = SFM_ZERO32;
    case (paddr)
      SFM_OFS_CTRL:      rdata_nxt = ctrl_r;
      SFM_OFS_ALARM:     rdata_nxt = alarm_r;
      SFM_OFS_ACTIVE:    rdata_nxt = {15'h0000, act_r, act_code_r};
      SFM_OFS_HIST_SEL:  rdata_nxt = sel_r;
      SFM_OFS_HIST_CODE: rdata_nxt = {16'h0000, hif.rd_code};         // RULE13 RULE14
      SFM_OFS_PARAM:     rdata_nxt = param_r;
      SFM_OFS_STATUS:    rdata_nxt = {24'h00_0000, pend_v_r, son, hif.count, st_r == SFM_ST_DONE,
                                      clr_pin};
      default:
      begin
        if (paddr >= SFM_OFS_SNAP0 && paddr < SFM_OFS_PARAM && paddr[1:0] == 2'b00)
          rdata_nxt = hif.rd_snap[3'((paddr - SFM_OFS_SNAP0) >> 2)];
      end
    endcase
  end

  // ==========================================================================
  // State registers and outputs
  always_ff @(posedge clk_sys or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      ctrl_r     <= SFM_ZERO32;
      alarm_r    <= SFM_ZERO32;
      sel_r      <= SFM_ZERO32;
      param_r    <= SFM_ZERO32;
      pend_r     <= SFM_ZERO32;
      pend_v_r   <= 1'b0;
      for (int j = 0; j < SFM_SNAP_NUM; j++)
        snapin_r[j] <= SFM_ZERO32;
      act_code_r <= SFM_CODE_NONE;
      act_r      <= 1'b0;
      hold_r     <= 24'h00_0000;
      st_r       <= SFM_ST_IDLE;
      prdata     <= SFM_ZERO32;
      pready     <= 1'b0;
      pslverr    <= 1'b0;
      code_out_b1 <= 1'b0;
      code_out_b2 <= 1'b0;
      code_out_b3 <= 1'b0;
      alarm_active <= 1'b0;
      settings_applied <= 1'b0;
    end
    else
    begin
      ctrl_r     <= ctrl_nxt;
      alarm_r    <= alarm_nxt;
      sel_r      <= sel_nxt;
      param_r    <= param_nxt;
      pend_r     <= pend_nxt;
      pend_v_r   <= pend_v_nxt;
      snapin_r   <= snapin_nxt;
      act_code_r <= act_code_nxt;
      act_r      <= act_nxt;
      hold_r     <= hold_nxt;
      st_r       <= st_nxt;
      prdata     <= (psel && !penable && !pwrite) ? rdata_nxt : prdata;
      pready     <= psel && !penable;
      pslverr    <= 1'b0;
      code_out_b1 <= act_nxt & al_nxt[0];                     // RULE17 RULE18
      code_out_b2 <= act_nxt & al_nxt[1];                     // RULE17
      code_out_b3 <= act_nxt & al_nxt[2];                     // RULE17
      alarm_active <= act_nxt;
      settings_applied <= !pend_v_nxt;
    end
  end
  logic unused_rd;
  assign unused_rd = rd;

endmodule

//--- dv/sfm_top_checker.sv
// Port checker of the servo fault manager
`timescale 1ns/1ps
module sfm_top_checker
#(
  parameter int RST_HOLD_CYC = 10
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // Drive pins
  input wire logic alarm_clear_request,
  input wire logic servo_enable,
  input wire logic alarm_cause_present,
  input wire logic code_out_b1,
  input wire logic code_out_b2,
  input wire logic code_out_b3,
  input wire logic alarm_active,
  input wire logic settings_applied
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // ==========================================================================
  // Length of the present clear level
  int hi_cnt_r;
  int hi_cnt_nxt;
  always_comb hi_cnt_nxt = alarm_clear_request ? hi_cnt_r + 1 : 0;
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
      hi_cnt_r <= 0;
    else
      hi_cnt_r <= hi_cnt_nxt;
  // ==========================================================================
  // Properties
  sequence s_access; psel && !penable ##1 psel && penable; endsequence
  sequence s_clr_off; !alarm_clear_request [*4]; endsequence
  sequence s_cause_on; alarm_cause_present [*4]; endsequence
  sequence s_en_on; servo_enable [*4]; endsequence
  sequence s_en_off; !servo_enable [*6]; endsequence
  property p_ready; s_access |-> pready; endproperty
  property p_no_err; psel && penable |-> !pslverr; endproperty
  property p_clr_off; s_clr_off |=> !$fell(alarm_active); endproperty
  property p_cause_on; s_cause_on |=> !$fell(alarm_active); endproperty
  property p_hold; $fell(alarm_active) |-> hi_cnt_r >= RST_HOLD_CYC; endproperty
  property p_en_on; s_en_on |=> !$rose(settings_applied); endproperty
  property p_en_off; s_en_off |-> ##[0:4] settings_applied; endproperty
  property p_idle;
    !alarm_active [*3] |-> !(code_out_b1 || code_out_b2 || code_out_b3);
  endproperty
  a_ready: assert property (p_ready) else $error("pready missing in access");
  a_no_err: assert property (p_no_err) else $error("pslverr raised");
  a_clr_off: assert property (p_clr_off)
    else $error("alarm cleared without clear level");
  a_cause_on: assert property (p_cause_on)
    else $error("alarm cleared with cause present");
  a_hold: assert property (p_hold)
    else $error("alarm cleared by short clear level");
  a_en_on: assert property (p_en_on)
    else $error("setting applied while enabled");
  a_en_off: assert property (p_en_off)
    else $error("setting not applied while disabled");
  a_idle: assert property (p_idle)
    else $error("code pins set with no alarm");
endmodule

//--- dv/sfm_host_model.sv
// Host controller model driving the drive pins
`timescale 1ns/1ps
module sfm_host_model
(
  // Clock
  input wire logic        clk_sys,
  // Commands from the bench
  input wire logic        en_cmd,
  input wire logic        cause_cmd,
  input wire logic        clr_go,
  input wire logic [15:0] clr_len,
  // Drive pins
  output logic            servo_enable,
  output logic            alarm_cause_present,
  output logic            alarm_clear_request,
  output logic            busy
);
  logic [15:0] cnt_r;
  initial
  begin
    servo_enable = 1'b0;
    alarm_cause_present = 1'b0;
    cnt_r = 16'h0000;
  end
  // Enable and cause pins follow the bench commands one clock later
  always @(posedge clk_sys)
  begin
    servo_enable <= en_cmd;
    alarm_cause_present <= cause_cmd;
    if (clr_go)
      cnt_r <= clr_len;
    else if (cnt_r != 16'h0000)
      cnt_r <= cnt_r - 16'h0001;
  end
  assign alarm_clear_request = (cnt_r != 16'h0000);
  assign busy = alarm_clear_request;
endmodule

//--- dv/servo_fault_manager_tb.sv
// Self-checking testbench of the servo fault manager
`timescale 1ns/1ps
module servo_fault_manager_tb;
  import sfm_pkg::*;
  localparam int HOLD = 10;
  logic clk_sys, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rnd, p1, p2;
  logic en_cmd, cause_cmd, clr_go, busy, clr_pin, en_pin, cause_pin;
  logic b1, b2, b3, alarm_active, settings_applied;
  logic [15:0] clr_len;
  logic [31:0] exp_q[$];
  int failures, compares, seed, i;
  // ==========================================================================
  // Design and host model
  sfm_top #(.RST_HOLD_CYC(HOLD)) dut (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .alarm_clear_request(clr_pin),
    .servo_enable(en_pin), .alarm_cause_present(cause_pin), .code_out_b1(b1),
    .code_out_b2(b2), .code_out_b3(b3), .alarm_active(alarm_active),
    .settings_applied(settings_applied));
  sfm_host_model u_host (.clk_sys(clk_sys), .en_cmd(en_cmd), .cause_cmd(cause_cmd),
    .clr_go(clr_go), .clr_len(clr_len), .servo_enable(en_pin),
    .alarm_cause_present(cause_pin), .alarm_clear_request(clr_pin), .busy(busy));
  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // ==========================================================================
  // Tasks
  function automatic logic [2:0] pat(input logic [15:0] c);
    case (c[11:0])
      12'h400: pat = 3'b011;
      12'h500: pat = 3'b010;
      12'hB00: pat = 3'b100;
      default: pat = c[3:1];
    endcase
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    compares++;
    if (s !== e)
    begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic complete_run;
    if (failures == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      failures++;
      complete_run();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, SFM_ZERO32);
  endtask
  task automatic raise(input logic [15:0] c);
    rnd = $random(seed);
    apb(1'b1, SFM_OFS_SNAPIN, rnd);
    apb(1'b1, SFM_OFS_ALARM, {16'h0000, c});
  endtask
  task automatic act(input logic [15:0] c, input logic on);
    rd(SFM_OFS_ACTIVE, {15'h0000, on, c});
    chk("code pins", {29'h0000_0000, on ? pat(c) : 3'h0}, {29'h0000_0000, b3, b2, b1});
  endtask
  task automatic clr(input int len);
    int n;
    clr_len <= len[15:0];
    clr_go <= 1'b1;
    @(posedge clk_sys);
    clr_go <= 1'b0;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (busy !== 1'b0 && n < 200);
    if (busy !== 1'b0)
    begin
      failures++;
      complete_run();
    end
    repeat (4) @(posedge clk_sys);
  endtask
  task automatic hist(input logic [3:0] n, input logic [15:0] c);
    apb(1'b1, SFM_OFS_HIST_SEL, {28'h000_0000, n});
    rd(SFM_OFS_HIST_CODE, {16'h0000, c});
  endtask
  // Read data against the oldest note
  always @(posedge clk_sys)
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0)
      chk("read data", exp_q.pop_front(), prdata);
  // ==========================================================================
  // Main sequence
  initial
  begin
    seed = 70;
    failures = 0;
    compares = 0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {en_cmd, cause_cmd, clr_go, clr_len, rst_n} = '0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    apb(1'b1, SFM_OFS_CTRL, 32'h0000_0008);
    rd(SFM_OFS_HIST_CODE, SFM_ZERO32);
    rd(8'hFC, SFM_ZERO32);
    raise(16'h4123);
    act(16'h0000, 1'b0);
    p1 = $random(seed);
    p2 = $random(seed);
    apb(1'b1, SFM_OFS_PARAM, p1);
    en_cmd <= 1'b1;
    repeat (4) @(posedge clk_sys);
    apb(1'b1, SFM_OFS_PARAM, p2);
    raise(16'hE12F);
    act(16'hE12F, 1'b1);
    clr(HOLD - 2);
    act(16'hE12F, 1'b1);
    apb(1'b1, SFM_OFS_CTRL, 32'h0000_000C);
    clr(HOLD * 3);
    act(16'hE12F, 1'b1);
    apb(1'b1, SFM_OFS_CTRL, 32'h0000_0008);
    clr(HOLD * 3);
    act(16'hE12F, 1'b0);
    chk("settings applied", 32'h0000_0000, {31'h0000_0000, settings_applied});
    rd(SFM_OFS_PARAM, p1);
    en_cmd <= 1'b0;
    repeat (8) @(posedge clk_sys);
    rd(SFM_OFS_PARAM, p2);
    chk("settings applied", 32'h0000_0001, {31'h0000_0000, settings_applied});
    en_cmd <= 1'b1;
    raise(16'h612F);
    raise(16'h2000);
    act(16'h2000, 1'b1);
    raise(16'hE00F);
    act(16'h2000, 1'b1);
    clr(HOLD * 3);
    act(16'h2000, 1'b1);
    en_cmd <= 1'b0;
    cause_cmd <= 1'b1;
    clr(HOLD * 3);
    act(16'h2000, 1'b1);
    cause_cmd <= 1'b0;
    clr(HOLD * 3);
    act(16'h2000, 1'b0);
    raise(16'h2400);
    act(16'h2400, 1'b1);
    clr(HOLD * 2);
    raise(16'h2500);
    act(16'h2500, 1'b1);
    clr(HOLD * 2);
    raise(16'h2B00);
    act(16'h2B00, 1'b1);
    clr(HOLD * 2);
    raise(16'h0FFF);
    clr(HOLD * 3);
    act(16'h0FFF, 1'b1);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    apb(1'b1, SFM_OFS_CTRL, 32'h0000_0008);
    for (i = 0; i < 11; i++)
    begin
      raise({12'hE10, i[3:0]});
      clr(HOLD * 2);
    end
    hist(4'h0, 16'hE10A);
    rd(SFM_OFS_SNAP0, rnd);
    hist(4'h9, 16'hE101);
    raise(16'hE106);
    clr(HOLD * 2);
    hist(4'h0, 16'hE10A);
    raise(16'hE101);
    clr(HOLD * 2);
    hist(4'h0, 16'hE101);
    hist(4'h9, 16'hE102);
    for (i = 0; i < 4; i++)
    begin
      raise({12'hE20, i[3:0]});
      clr(HOLD * 2);
      apb(1'b1, SFM_OFS_CTRL, {28'h000_0000, 2'b10, i[1:0]});
      hist(4'h0, (i == 1 || i == 2) ? 16'h0000 : {12'hE20, i[3:0]});
    end
    repeat (4) @(posedge clk_sys);
    complete_run();
  end
endmodule

bind sfm_top sfm_top_checker #(.RST_HOLD_CYC(RST_HOLD_CYC)) u_chk (.clk_sys(clk_sys),
  .rst_n(rst_n), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .alarm_clear_request(alarm_clear_request), .servo_enable(servo_enable),
  .alarm_cause_present(alarm_cause_present), .code_out_b1(code_out_b1),
  .code_out_b2(code_out_b2), .code_out_b3(code_out_b3), .alarm_active(alarm_active),
  .settings_applied(settings_applied));
